// ### verilog/counter_array_pkg.sv
// Constants shared by the counter array and its channel modules.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package counter_array_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h0C;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h10;
    localparam logic [7:0] OFS_GLOBAL_EN = 8'h14;
    localparam logic [7:0] OFS_CHAN_VALUE = 8'h20;
    localparam logic [7:0] OFS_CHAN_MODE = 8'h40;
    localparam int CHAN_STRIDE = 4;

    // ==========================================================
    // Field positions of array_mode_reg
    localparam int MODE_WDOG = 0;
    localparam int MODE_TB_LSB = 1;
    localparam int MODE_CLS_LSB = 4;
    localparam int MODE_IDLE = 7;
    localparam logic [7:0] MODE_RESET = 8'h01;

    // Status, enable layout: overflow, intermediate, then one per channel
    localparam int ST_OVF = 0;
    localparam int ST_IOVF = 1;
    localparam int ST_CHAN = 2;

    // Global enable bits
    localparam int GE_GLOBAL = 0;
    localparam int GE_ARRAY = 1;

    // Channel mode bits
    localparam int CM_COMPARE = 0;
    localparam int CM_MATCH_FLAG = 1;
    localparam int CM_TOGGLE = 2;
    localparam int CM_CAP_RISE = 3;
    localparam int CM_CAP_FALL = 4;
    localparam int CM_WIDTH = 5;

    // ==========================================================
    // Timebase
    typedef enum logic [2:0]
    {
        TB_SYS_DIV12 = 3'b000,
        TB_SYS_DIV4 = 3'b001,
        TB_TIMER0 = 3'b010,
        TB_EVENT_PIN = 3'b011,
        TB_SYS = 3'b100,
        TB_EXT_DIV8 = 3'b101
    } timebase_t;

    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/chan_if.sv
// Bundle between the counter array core and one capture/compare channel.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface chan_if;
    logic [15:0] count;
    logic tick;
    logic [4:0] mode;
    logic wr_en;
    logic [15:0] wr_data;
    logic [15:0] value;
    logic event_pulse;

    modport core (output count, tick, mode, wr_en, wr_data, input value, event_pulse);
    modport chan (input count, tick, mode, wr_en, wr_data, output value, event_pulse);
endinterface

// ### verilog/capture_compare_channel.sv
// One 16-bit capture/compare channel with its own I/O line.
// Assumes pin input is synchronous to core_clk.
`timescale 1ns/100ps
module capture_compare_channel
    import counter_array_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Core side
    chan_if.chan bus,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n
);
    logic pin_prev;
    logic match;
    logic capture;

    // ==========================================================
    // Match and capture detection
    always_comb
    begin
        match = bus.tick && bus.mode[CM_COMPARE] && (bus.count == bus.value);
        capture = (bus.mode[CM_CAP_RISE] && pin_in && !pin_prev)
            || (bus.mode[CM_CAP_FALL] && !pin_in && pin_prev);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_prev <= 1'b0;
            bus.value <= 16'h0000;
            bus.event_pulse <= 1'b0;
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            pin_prev <= pin_in;
            // Software write loses to a capture in the same cycle: the capture is an event
            if (capture)
                bus.value <= bus.count;
            else if (bus.wr_en)
                bus.value <= bus.wr_data;
            bus.event_pulse <= capture || (match && bus.mode[CM_MATCH_FLAG]);
            pin_oe_n <= !bus.mode[CM_TOGGLE];
            if (match && bus.mode[CM_TOGGLE])
                pin_out <= !pin_out;
        end
    end

endmodule // capture_compare_channel

// ### verilog/counter_array.sv
// Programmable counter array: 16-bit main counter, timebase, interrupt tree,
// and capture/compare channels, with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to core_clk except ext_osc_div8.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps

module counter_array
    import counter_array_pkg::*;
#(
    parameter int CHANNELS = 3
)
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Count sources and processor state
    input wire logic timer0_overflow,
    input wire logic event_clock_pin,
    input wire logic ext_osc_div8,
    input wire logic cpu_idle,
    // Channel lines
    input wire logic [CHANNELS-1:0] channel_io_line_in,
    output logic [CHANNELS-1:0] channel_io_line_out,
    output logic [CHANNELS-1:0] channel_io_line_oe_n,
    // Interrupt
    output logic irq
);
    import counter_array_pkg::*;

    localparam int FLAGS = ST_CHAN + CHANNELS;

    // Status and enable registers are one byte wide: two array flags plus six channels at most
    generate
        if (CHANNELS < 1 || CHANNELS > 6)
        begin : gen_bad_channels
            $error("CHANNELS must lie between 1 and 6");
        end
    endgenerate

    logic [15:0] count;
    logic [7:0] snapshot;
    logic [7:0] array_mode_reg;
    logic [FLAGS-1:0] status;
    logic [FLAGS-1:0] irq_enable;
    logic [1:0] global_en;
    logic [CM_WIDTH-1:0] chan_mode [CHANNELS];
    logic [3:0] prescale;
    logic event_prev;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic tick;
    logic [FLAGS-1:0] flag_set;
    logic [CHANNELS-1:0] chan_event;
    logic [15:0] chan_value [CHANNELS];
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic wr_ok;
    logic rd_take;
    logic [31:0] next_rdata;
    logic next_rok;

    timebase_t timebase_select;
    logic [1:0] cycle_length_select;
    logic idle_suspend;
    logic watchdog_en;

    assign timebase_select = timebase_t'(array_mode_reg[MODE_TB_LSB +: 3]);
    assign cycle_length_select = array_mode_reg[MODE_CLS_LSB +: 2];
    assign idle_suspend = array_mode_reg[MODE_IDLE];
    assign watchdog_en = array_mode_reg[MODE_WDOG];

    // ==========================================================
    // Timebase
    // Prescaler counts 0 to 11; the divide-by-4 source taps its low bits
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            prescale <= 4'h0;
        else if (clk_en)
            prescale <= (prescale == DIV12_LAST) ? 4'h0 : prescale + 4'h1;
    end

    // Oscillator divider is foreign to core_clk: two flops, then edge detect
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
            event_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            ext_sync1 <= ext_osc_div8;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
            event_prev <= event_clock_pin;
        end
    end

    always_comb
    begin
        case (timebase_select)
            TB_SYS_DIV12: tick = (prescale == DIV12_LAST);
            TB_SYS_DIV4: tick = (prescale[1:0] == DIV4_LAST[1:0]);
            TB_TIMER0: tick = timer0_overflow;
            // Faster pin edges than core_clk over four are not guaranteed to count
            TB_EVENT_PIN: tick = event_prev && !event_clock_pin;
            TB_SYS: tick = 1'b1;
            TB_EXT_DIV8: tick = ext_sync2 && !ext_prev;
            default: tick = 1'b0;
        endcase
        if (idle_suspend && cpu_idle)
            tick = 1'b0;
    end

    // ==========================================================
    // Main counter and snapshot
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            count <= 16'h0000;
        else if (clk_en)
        begin
            if (do_write && wr_ok && aw_addr == OFS_COUNT_LOW)
                count[7:0] <= wval[7:0];
            else if (do_write && wr_ok && aw_addr == OFS_COUNT_HIGH)
                count[15:8] <= wval[7:0];
            else if (tick)
                count <= count + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            snapshot <= 8'h00;
        else if (clk_en && rd_take && s_axi_araddr == OFS_COUNT_LOW)
            snapshot <= count[15:8];
    end

    // ==========================================================
    // Event flags and interrupt
    always_comb
    begin
        flag_set = '0;
        flag_set[ST_OVF] = tick && (count == 16'hFFFF);
        flag_set[ST_IOVF] = tick && (&count[7:0])
            && (count[10:8] | ~(3'h7 >> (2'h3 - cycle_length_select))) == 3'h7;
        flag_set[FLAGS-1:ST_CHAN] = chan_event;
    end

    // A flag raised in the cycle that software clears it survives
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            status <= '0;
        else if (clk_en)
        begin
            if (do_write && wr_ok && aw_addr == OFS_STATUS)
                status <= (status & ~wval[FLAGS-1:0]) | flag_set;
            else
                status <= status | flag_set;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else if (clk_en)
            irq <= (|(status & irq_enable))
                && global_en[GE_GLOBAL] && global_en[GE_ARRAY];
    end

    // ==========================================================
    // Channels
    chan_if ch_bus [CHANNELS] ();

    generate
        for (genvar g = 0; g < CHANNELS; g++)
        begin : gen_chan
            assign ch_bus[g].count = count;
            assign ch_bus[g].tick = tick;
            assign ch_bus[g].mode = chan_mode[g];
            assign ch_bus[g].wr_en = clk_en && do_write && wr_ok
                && aw_addr == OFS_CHAN_VALUE + 8'(g * CHAN_STRIDE);
            assign ch_bus[g].wr_data = wval[15:0];
            assign chan_value[g] = ch_bus[g].value;
            assign chan_event[g] = ch_bus[g].event_pulse;

            capture_compare_channel u_chan
            (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .clk_en(clk_en),
                .bus(ch_bus[g]),
                .pin_in(channel_io_line_in[g]),
                .pin_out(channel_io_line_out[g]),
                .pin_oe_n(channel_io_line_oe_n[g])
            );

            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    chan_mode[g] <= '0;
                else if (clk_en && do_write && wr_ok && aw_addr == OFS_CHAN_MODE + 8'(g * CHAN_STRIDE))
                    chan_mode[g] <= wval[CM_WIDTH-1:0];
            end
        end
    endgenerate

    // ==========================================================
    // Control registers
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            array_mode_reg <= MODE_RESET;
            irq_enable <= '0;
            global_en <= 2'h0;
        end
        else if (clk_en && do_write && wr_ok)
        begin
            if (aw_addr == OFS_MODE)
                array_mode_reg <= wval[7:0];
            else if (aw_addr == OFS_IRQ_EN)
                irq_enable <= wval[FLAGS-1:0];
            else if (aw_addr == OFS_GLOBAL_EN)
                global_en <= wval[1:0];
        end
    end

    // ==========================================================
    // AXI4-Lite write channel
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wval = w_data & wmask;

    // Watchdog mode accepts only an all-zero write to the mode register, and locks the counter
    always_comb
    begin
        if (aw_addr == OFS_MODE)
            wr_ok = !watchdog_en || wval[7:0] == 8'h00;
        else if (aw_addr == OFS_COUNT_LOW || aw_addr == OFS_COUNT_HIGH)
            wr_ok = !watchdog_en;
        else if (aw_addr == OFS_STATUS || aw_addr == OFS_IRQ_EN || aw_addr == OFS_GLOBAL_EN)
            wr_ok = 1'b1;
        else if (aw_addr >= OFS_CHAN_VALUE && aw_addr < OFS_CHAN_VALUE + 8'(CHANNELS * CHAN_STRIDE))
            wr_ok = aw_addr[1:0] == 2'h0;
        else if (aw_addr >= OFS_CHAN_MODE && aw_addr < OFS_CHAN_MODE + 8'(CHANNELS * CHAN_STRIDE))
            wr_ok = aw_addr[1:0] == 2'h0;
        else
            wr_ok = 1'b0;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    assign rd_take = s_axi_arvalid && s_axi_arready;

    // Reads have no side effect on the counter itself
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rok = 1'b1;
        if (s_axi_araddr == OFS_MODE)
            next_rdata[7:0] = array_mode_reg;
        else if (s_axi_araddr == OFS_STATUS)
            next_rdata[FLAGS-1:0] = status;
        else if (s_axi_araddr == OFS_IRQ_EN)
            next_rdata[FLAGS-1:0] = irq_enable;
        else if (s_axi_araddr == OFS_COUNT_LOW)
            next_rdata[7:0] = count[7:0];
        else if (s_axi_araddr == OFS_COUNT_HIGH)
            next_rdata[7:0] = snapshot;
        else if (s_axi_araddr == OFS_GLOBAL_EN)
            next_rdata[1:0] = global_en;
        else
        begin
            next_rok = 1'b0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (s_axi_araddr == OFS_CHAN_VALUE + 8'(i * CHAN_STRIDE))
                begin
                    next_rdata[15:0] = chan_value[i];
                    next_rok = 1'b1;
                end
                if (s_axi_araddr == OFS_CHAN_MODE + 8'(i * CHAN_STRIDE))
                begin
                    next_rdata[CM_WIDTH-1:0] = chan_mode[i];
                    next_rok = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (rd_take)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence wrap_seq;
        clk_en && tick && count == 16'hFFFF && !do_write;
    endsequence

    sequence low_read_seq;
        clk_en && rd_take && s_axi_araddr == OFS_COUNT_LOW;
    endsequence

    AST_WRAP_ZERO: assert property (wrap_seq |=> count == 16'h0000)
        else $error("counter did not wrap to zero");
    AST_OVF_FLAG: assert property (wrap_seq |=> status[ST_OVF])
        else $error("overflow flag not set on wrap");
    AST_SNAPSHOT: assert property (low_read_seq |=> snapshot == $past(count[15:8]))
        else $error("snapshot does not hold high byte");
    AST_READ_NO_DISTURB: assert property (low_read_seq ##0 (!tick && !do_write) |=> $stable(count))
        else $error("read disturbed the counter");
    AST_IDLE_HOLD: assert property (clk_en && idle_suspend && cpu_idle && !do_write |=> $stable(count))
        else $error("counter moved during suspended idle");
    AST_FLAG_STICKY: assert property (clk_en && status[ST_OVF] && !do_write |=> status[ST_OVF])
        else $error("overflow flag cleared without software");
    AST_IRQ_GATE: assert property (clk_en && !(global_en[GE_GLOBAL] && global_en[GE_ARRAY]) |=> !irq)
        else $error("interrupt raised without global enables");
    AST_IRQ_OR: assert property (clk_en && (|(status & irq_enable)) && (&global_en) |=> irq)
        else $error("enabled flag did not raise interrupt");
    AST_CHAN_FLAG: assert property (clk_en && chan_event[0] |=> status[ST_CHAN])
        else $error("channel event not recorded");
    AST_WDOG_LOCK: assert property (do_write && watchdog_en && aw_addr == OFS_COUNT_LOW
        |=> s_axi_bresp == RESP_SLVERR)
        else $error("counter write accepted in watchdog mode");

endmodule // counter_array

// ### tb/pin_partner.sv
// Far-side model: event clock source, external oscillator and channel pins.
// Assumes core_clk is the array's system clock.
`timescale 1ns/100ps
module pin_partner
(
    // Clock
    input wire logic core_clk,
    // Channel lines from the array
    input wire logic [2:0] line_out,
    input wire logic [2:0] line_oe_n,
    // Sources toward the array
    output logic event_clock_pin,
    output logic ext_osc_div8,
    output logic [2:0] line_in
);
    logic [3:0] phase = 4'h0;
    // Free running, unrelated in phase and rate to core_clk
    initial
    begin
        ext_osc_div8 = 1'b0;
        forever #170 ext_osc_div8 = ~ext_osc_div8;
    end
    // One fall every 16 cycles keeps well under the quarter-rate limit; idles high
    always @(posedge core_clk)
        phase <= phase + 4'h1;
    assign event_clock_pin = ~phase[3];
    // Released lines sit at the pull-down level
    assign line_in = ~line_oe_n & line_out;
endmodule // pin_partner

// ### tb/test_counter_array.sv
// Self-checking bench for the counter array over AXI4-Lite.
// Assumes the pin_partner model drives the event and oscillator inputs.
`timescale 1ns/100ps
module test_counter_array;
    import counter_array_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic timer0_overflow = 1'b0, cpu_idle = 1'b0, event_clock_pin, ext_osc_div8;
    logic [2:0] line_in, line_out, line_oe_n;
    logic [3:0] t0_div = 4'h0;
    int err_count = 0;
    int total_checks = 0;
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        t0_div <= t0_div + 4'h1;
        timer0_overflow <= (t0_div == 4'hF);
    end
    counter_array counter_array_i (.core_clk, .arst_n, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer0_overflow, .event_clock_pin, .ext_osc_div8,
        .cpu_idle, .channel_io_line_in(line_in), .channel_io_line_out(line_out),
        .channel_io_line_oe_n(line_oe_n), .irq);
    pin_partner pin_partner_i (.core_clk, .line_out, .line_oe_n, .event_clock_pin, .ext_osc_div8, .line_in);
    // ==========
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    // Stops the counter on the reserved timebase, loads it, clears flags
    task automatic set_cnt(input logic [15:0] v);
        wr(OFS_MODE, 32'h0C, RESP_OKAY);
        wr(OFS_COUNT_HIGH, 32'(v[15:8]), RESP_OKAY);
        wr(OFS_COUNT_LOW, 32'(v[7:0]), RESP_OKAY);
        wr(OFS_STATUS, 32'hFF, RESP_OKAY);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        finish_test();
    end
    // ==========
    // Tests
    initial
    begin : main
        logic [31:0] d, e;
        logic [15:0] c;
        int i, s;
        logic [7:0] codes [6];
        int ex [6];
        codes = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A};
        ex = '{8, 24, 6, 6, 96, 28};
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(OFS_MODE, d, RESP_OKAY);
        chk(d, 32'(MODE_RESET));
        wr(OFS_COUNT_LOW, 32'h55, RESP_SLVERR);
        wr(OFS_MODE, 32'h08, RESP_SLVERR);
        wr(OFS_MODE, 32'h00, RESP_OKAY);
        rd(8'h1C, d, RESP_SLVERR);
        // Window is about 100 cycles, so each count carries some slack
        for (i = 0; i < 6; i++)
        begin
            set_cnt(16'h0000);
            wr(OFS_MODE, 32'(codes[i]), RESP_OKAY);
            repeat (96) @(posedge core_clk);
            wr(OFS_MODE, 32'h0C, RESP_OKAY);
            rd(OFS_COUNT_LOW, d, RESP_OKAY);
            rd(OFS_COUNT_HIGH, e, RESP_OKAY);
            c = {e[7:0], d[7:0]};
            chk(32'(c >= ex[i] - 1 && c <= ex[i] + ex[i] / 16 + 2), 1);
        end
        set_cnt(16'hFFF0);
        wr(OFS_MODE, 32'h08, RESP_OKAY);
        repeat (30) @(posedge core_clk);
        rd(OFS_STATUS, d, RESP_OKAY);
        chk(32'(d[ST_OVF]), 1);
        wr(OFS_IRQ_EN, 32'h1, RESP_OKAY);
        wr(OFS_GLOBAL_EN, 32'h1, RESP_OKAY);
        chk(32'(irq), 0);
        wr(OFS_GLOBAL_EN, 32'h3, RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 1);
        rd(OFS_STATUS, d, RESP_OKAY);
        chk(32'(d[ST_OVF]), 1);
        wr(OFS_STATUS, 32'h1, RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 0);
        wr(OFS_IRQ_EN, 32'h2, RESP_OKAY);
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 1);
        set_cnt(16'h12F8);
        wr(OFS_MODE, 32'h08, RESP_OKAY);
        rd(OFS_COUNT_LOW, d, RESP_OKAY);
        repeat (20) @(posedge core_clk);
        rd(OFS_COUNT_HIGH, e, RESP_OKAY);
        chk(e, (d[7:0] >= 8'hF8) ? 32'h12 : 32'h13);
        cpu_idle <= 1'b1;
        rd(OFS_COUNT_LOW, d, RESP_OKAY);
        rd(OFS_COUNT_LOW, e, RESP_OKAY);
        chk(32'(d !== e), 1);
        wr(OFS_MODE, 32'h88, RESP_OKAY);
        rd(OFS_COUNT_LOW, d, RESP_OKAY);
        rd(OFS_COUNT_LOW, e, RESP_OKAY);
        chk(e, d);
        cpu_idle <= 1'b0;
        rd(OFS_COUNT_LOW, d, RESP_OKAY);
        chk(32'(d !== e), 1);
        // Start i reaches all ones in the low 8+s bits only when i >= s
        for (s = 0; s < 4; s++)
            for (i = 0; i < 4; i++)
            begin
                set_cnt(16'h00FA | 16'(((1 << i) - 1) << 8));
                wr(OFS_MODE, 32'h08 | 32'(s << MODE_CLS_LSB), RESP_OKAY);
                repeat (12) @(posedge core_clk);
                rd(OFS_STATUS, d, RESP_OKAY);
                chk(d, (i >= s) ? 32'h2 : 32'h0);
            end
        for (i = 0; i < 3; i++)
        begin
            set_cnt(16'h0000);
            wr(OFS_CHAN_VALUE + 8'(CHAN_STRIDE * i), 32'h20, RESP_OKAY);
            // Toggle on match makes a rising line edge, captured one cycle later
            wr(OFS_CHAN_MODE + 8'(CHAN_STRIDE * i), 32'h0F, RESP_OKAY);
            wr(OFS_MODE, 32'h08, RESP_OKAY);
            repeat (50) @(posedge core_clk);
            rd(OFS_STATUS, d, RESP_OKAY);
            chk(d, 32'(4 << i));
            chk(32'({line_out[i], line_oe_n[i]}), 2);
            rd(OFS_CHAN_VALUE + 8'(CHAN_STRIDE * i), d, RESP_OKAY);
            chk(d, 32'h21);
            wr(OFS_CHAN_MODE + 8'(CHAN_STRIDE * i), 32'h00, RESP_OKAY);
        end
        // Channel 0 line now stands high, so the next toggle gives a falling edge
        set_cnt(16'h0000);
        wr(OFS_CHAN_VALUE, 32'h20, RESP_OKAY);
        wr(OFS_CHAN_MODE, 32'h17, RESP_OKAY);
        wr(OFS_MODE, 32'h08, RESP_OKAY);
        repeat (50) @(posedge core_clk);
        rd(OFS_CHAN_VALUE, d, RESP_OKAY);
        chk(d, 32'h21);
        chk(32'({line_out[0], line_oe_n[0]}), 0);
        finish_test();
    end
endmodule // test_counter_array
